// ===== include/gdp_pkg.sv
// Shared constants and helpers of the gate driver protection block
package gdp_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Blanking is counted in ticks of this length
    localparam int BLANK_TICK_NS = 100;
    localparam int BLANK_TICK_CYC = (BLANK_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 3;
    localparam int BLANK_W = 8;
    // Mode watchdog overflow time, rounded down to cycles
    localparam int WDOG_TIME_US = 1000;
    localparam int WDOG_CYC = WDOG_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int WDOG_W = 16;
    // Sticky error flag positions
    localparam int NFLAG = 8;
    localparam int FLG_OVC = 0;
    localparam int FLG_EN = 1;
    localparam int FLG_PRST = 2;
    localparam int FLG_PUV = 3;
    localparam int FLG_POV = 4;
    localparam int FLG_NUV = 5;
    localparam int FLG_NOV = 6;
    localparam int FLG_MTO = 7;
    // Secondary supply monitor positions
    localparam int NSUP = 4;
    localparam int SUP_PUV = 0;
    localparam int SUP_POV = 1;
    localparam int SUP_NUV = 2;
    localparam int SUP_NOV = 3;
    localparam logic NEG_OVER_DIS_RST = 1'b1;

    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction
endpackage

// ===== include/gdp_prot_if.sv
// Carrier between the protection top and its blanking and watchdog helpers
`timescale 1ns/1ps
`default_nettype none
interface gdp_prot_if;
    logic sec_rst;
    logic on_cmd;
    logic [gdp_pkg::BLANK_W-1:0] blank_time;
    logic blank_done;
    logic sel_p;
    logic ref_p;
    logic sel_m;
    logic ref_m;
    logic mode_active;
    logic mode_timeout;
    modport blank (input sec_rst, on_cmd, blank_time, output blank_done);
    modport wdog (input sec_rst, sel_p, ref_p, output sel_m, ref_m, mode_active, mode_timeout);
endinterface
`default_nettype wire

// ===== rtl/gdp_blank_timer.sv
// Overcurrent blanking window timer started at each turn-on
`timescale 1ns/1ps
`default_nettype none
module gdp_blank_timer (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_b,   // Async reset, active low
    gdp_prot_if.blank pif       // Blanking request and done
);
    localparam int TW = gdp_pkg::TICK_W;
    localparam logic [TW-1:0] TICK_LAST = TW'(gdp_pkg::BLANK_TICK_CYC - 1);

    typedef struct packed {
        logic [TW-1:0] tick;
        logic [gdp_pkg::BLANK_W-1:0] cnt;
        logic done;
        logic on_d;
    } gdp_blank_st_t;

    gdp_blank_st_t st;
    gdp_blank_st_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.on_d = pif.on_cmd;
        next_st.tick = (st.tick == TICK_LAST) ? '0 : st.tick + 1'b1;
        if (pif.sec_rst || !pif.on_cmd)
        begin
            next_st = '0;
        end
        else if (!st.on_d)
        begin
            // Window restarts on every turn-on
            next_st.tick = '0;
            next_st.cnt = '0;
            next_st.done = (pif.blank_time == '0);
        end
        else if (!st.done && st.tick == TICK_LAST)
        begin
            next_st.cnt = st.cnt + 1'b1;
            next_st.done = (st.cnt + 1'b1 == pif.blank_time);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            st <= '0;
        else
            st <= next_st;
    end

    assign pif.blank_done = st.done;

    a_blank_off_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !pif.on_cmd |=> !pif.blank_done) else $error("blanking done while output off");
    a_blank_min_len: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        ($rose(pif.on_cmd) && pif.blank_time != '0) |-> !pif.blank_done [*6])
        else $error("blanking window ended early");
endmodule
`default_nettype wire

// ===== rtl/gdp_mode_wdog.sv
// Mirrored over-voltage mode select with refresh watchdog
`timescale 1ns/1ps
`default_nettype none
module gdp_mode_wdog #(
    parameter int P_WDOG_CYC = gdp_pkg::WDOG_CYC // Watchdog length in cycles
) (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_b,   // Async reset, active low
    gdp_prot_if.wdog pif        // Mode select carrier
);
    localparam int WW = gdp_pkg::WDOG_W;
    localparam logic [WW-1:0] WDOG_LAST = WW'(P_WDOG_CYC - 1);

    typedef struct packed {
        logic sel_m;
        logic ref_m;
        logic ref_d;
        logic both_d;
        logic active;
        logic timeout;
        logic [WW-1:0] timer;
    } gdp_wdog_st_t;

    gdp_wdog_st_t st;
    gdp_wdog_st_t next_st;
    logic both;
    logic ref_rise;

    always_comb
    begin
        next_st = st;
        both = st.sel_m & st.ref_m;
        ref_rise = gdp_pkg::rise(st.ref_m, st.ref_d);
        next_st.sel_m = pif.sel_p;
        next_st.ref_m = pif.ref_p;
        next_st.ref_d = st.ref_m;
        next_st.both_d = both;
        next_st.timeout = 1'b0;
        if (pif.sec_rst)
            next_st = '0;
        else if (!st.sel_m)
            next_st.active = 1'b0;
        else if (st.active && st.timer == WDOG_LAST)
        begin
            next_st.active = 1'b0;
            next_st.timeout = 1'b1;
        end
        else if (!st.active && gdp_pkg::rise(both, st.both_d))
        begin
            // Set only on a fresh select-and-refresh, so a timeout is not undone at once
            next_st.active = 1'b1;
            next_st.timer = '0;
        end
        else if (st.active)
            next_st.timer = ref_rise ? '0 : st.timer + 1'b1;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            st <= '0;
        else
            st <= next_st;
    end

    assign pif.sel_m = st.sel_m;
    assign pif.ref_m = st.ref_m;
    assign pif.mode_active = st.active;
    assign pif.mode_timeout = st.timeout;

    a_mode_sel_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !st.sel_m |=> !st.active) else $error("mode stayed active without select");
    a_mode_timeout: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (st.active && st.sel_m && !pif.sec_rst && st.timer == WDOG_LAST) |=> (!st.active && st.timeout))
        else $error("watchdog overflow not handled");
    a_mode_refresh: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (st.active && st.sel_m && !pif.sec_rst && ref_rise && st.timer != WDOG_LAST) |=> st.timer == '0)
        else $error("refresh did not restart watchdog");
endmodule
`default_nettype wire

// ===== rtl/gdp_protect.sv
// Top of the gate driver protection logic: overcurrent, enable and supply supervision
`timescale 1ns/1ps
`default_nettype none
module gdp_protect #(
    parameter int P_WDOG_CYC = gdp_pkg::WDOG_CYC // Mode watchdog length in cycles
) (
    input wire logic i_sys_clk,                        // System clock, 50 MHz
    input wire logic i_rst_b,                          // Async reset, active low
    input wire logic i_out_on_cmd,                     // Output-on command
    input wire logic i_ocp_comp,                       // Raw overcurrent comparator
    input wire logic [7:0] i_overcurrent_blanking_time, // Blanking in 100 ns ticks
    input wire logic i_en_valid,                       // External enable is valid
    input wire logic i_prim_uv,                        // Primary undervoltage monitor
    input wire logic i_pos_uv,                         // Positive supply under
    input wire logic i_pos_ov,                         // Positive supply over
    input wire logic i_neg_uv,                         // Negative supply under
    input wire logic i_neg_ov,                         // Negative supply over
    input wire logic i_pos_below_rst,                  // Positive supply below reset level
    input wire logic i_over_mode_select_primary,       // Host mode select
    input wire logic i_over_mode_refresh_primary,      // Host mode refresh
    input wire logic i_cfg_wr,                         // Config write strobe
    input wire logic i_cfg_neg_over_disable,           // Config data
    input wire logic [7:0] i_flag_clr,                 // Flag clear, one per flag
    input wire logic i_fast_react,                     // Fast reactivation pulse
    input wire logic i_reinit,                         // Full reinitialisation pulse
    output logic o_safe_off,                           // Safe turn-off pulse
    output logic o_regular_off,                        // Regular turn-off pulse
    output logic o_clamp_inhibit_delay,                // Apply clamp delay with turn-off
    output logic o_drive_permit,                       // Output may be switched on
    output logic o_fault_a_notify_n,                   // Fault A, active low
    output logic o_fault_b_notify_n,                   // Fault B, active low
    output logic o_reset_ready_n,                      // Reset/ready, low in reset
    output logic o_sec_reset,                          // Secondary logic held in reset
    output logic [7:0] o_flags,                        // Sticky error flags
    output logic o_overcurrent_compare_status,         // Blanked compare result
    output logic o_enable_valid_status,                // Enable validity
    output logic o_pos_under_monitor_status,           // Live positive under
    output logic o_pos_over_monitor_status,            // Live positive over
    output logic o_neg_under_monitor_status,           // Live negative under
    output logic o_neg_over_monitor_status,            // Live negative over
    output logic o_over_mode_select_mirror,            // Mirrored select
    output logic o_over_mode_refresh_mirror,           // Mirrored refresh
    output logic o_over_mode_active_status,            // Over mode: 1 notify only
    output logic o_neg_over_disable                    // Negative over disabled
);
    localparam int NS = gdp_pkg::NSUP;

    typedef struct packed {
        logic [gdp_pkg::NFLAG-1:0] flags;
        logic [NS-1:0] sup_d;
        logic [NS-1:0] bsup_d;
        logic [NS-1:0] mon;
        logic lock_a;
        logic lock_b;
        logic en_d;
        logic prim_d;
        logic neg_dis;
        logic ovc_stat;
        logic en_stat;
        logic safe_off;
        logic reg_off;
        logic clamp_dly;
        logic rst_rdy_n;
    } gdp_top_st_t;

    localparam gdp_top_st_t ST_RST = '{neg_dis: gdp_pkg::NEG_OVER_DIS_RST, default: '0};

    gdp_top_st_t st;
    gdp_top_st_t next_st;
    gdp_prot_if pif ();

    logic on_ok;
    logic ovc_hit;
    logic ovc_ev;
    logic en_ev;
    logic prim_ev;
    logic prim_rec;
    logic b_ev;
    logic [NS-1:0] sup;
    logic [NS-1:0] sup_ev;
    logic [NS-1:0] live_b;
    logic [gdp_pkg::NFLAG-1:0] set;

    assign pif.sec_rst = i_pos_below_rst;
    assign pif.on_cmd = i_out_on_cmd;
    assign pif.blank_time = i_overcurrent_blanking_time;
    assign pif.sel_p = i_over_mode_select_primary;
    assign pif.ref_p = i_over_mode_refresh_primary;

    gdp_blank_timer u_blank (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .pif(pif.blank)
    );

    gdp_mode_wdog #(
        .P_WDOG_CYC(P_WDOG_CYC)
    ) u_wdog (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .pif(pif.wdog)
    );

    always_comb
    begin
        next_st = st;
        on_ok = i_out_on_cmd && pif.blank_done;
        ovc_hit = on_ok && i_ocp_comp;
        ovc_ev = ovc_hit && !st.lock_a;
        en_ev = gdp_pkg::rise(st.en_d, i_en_valid);
        prim_ev = gdp_pkg::rise(i_prim_uv, st.prim_d);
        prim_rec = gdp_pkg::rise(st.prim_d, i_prim_uv);
        sup[gdp_pkg::SUP_PUV] = i_pos_uv;
        sup[gdp_pkg::SUP_POV] = i_pos_ov;
        sup[gdp_pkg::SUP_NUV] = i_neg_uv;
        sup[gdp_pkg::SUP_NOV] = i_neg_ov && !st.neg_dis;
        sup_ev = sup & ~st.sup_d;
        // Conditions that lock the output; notify-only mode drops positive over
        live_b = sup;
        live_b[gdp_pkg::SUP_POV] = i_pos_ov && !pif.mode_active;
        // A mode change back to class B with the fault present still locks
        b_ev = |(live_b & ~st.bsup_d);
        set = '0;
        set[gdp_pkg::FLG_OVC] = ovc_ev;
        set[gdp_pkg::FLG_EN] = en_ev;
        set[gdp_pkg::FLG_PRST] = prim_rec;
        set[gdp_pkg::FLG_PUV] = sup_ev[gdp_pkg::SUP_PUV];
        set[gdp_pkg::FLG_POV] = sup_ev[gdp_pkg::SUP_POV];
        set[gdp_pkg::FLG_NUV] = sup_ev[gdp_pkg::SUP_NUV];
        set[gdp_pkg::FLG_NOV] = sup_ev[gdp_pkg::SUP_NOV];
        set[gdp_pkg::FLG_MTO] = pif.mode_timeout;
        // A new event wins over a clear in the same cycle
        next_st.flags = (st.flags & ~i_flag_clr) | set;
        if (ovc_ev || en_ev)
            next_st.lock_a = 1'b1;
        else if (i_fast_react)
            next_st.lock_a = 1'b0;
        if (b_ev || prim_ev)
            next_st.lock_b = 1'b1;
        else if (i_reinit && !(|live_b) && !i_prim_uv)
            next_st.lock_b = 1'b0;
        next_st.safe_off = ovc_ev;
        next_st.reg_off = en_ev || b_ev || prim_ev;
        // Clamp delay only for regular turn-off; a safe turn-off overrides it
        next_st.clamp_dly = (en_ev || b_ev || prim_ev) && !ovc_ev;
        next_st.rst_rdy_n = !i_prim_uv;
        next_st.ovc_stat = ovc_hit;
        next_st.en_stat = i_en_valid;
        next_st.mon[gdp_pkg::SUP_PUV] = i_pos_uv;
        next_st.mon[gdp_pkg::SUP_POV] = i_pos_ov;
        next_st.mon[gdp_pkg::SUP_NUV] = i_neg_uv;
        next_st.mon[gdp_pkg::SUP_NOV] = i_neg_ov;
        if (pif.sec_rst)
            next_st.neg_dis = gdp_pkg::NEG_OVER_DIS_RST;
        else if (i_cfg_wr)
            next_st.neg_dis = i_cfg_neg_over_disable;
        next_st.en_d = i_en_valid;
        next_st.prim_d = i_prim_uv;
        next_st.sup_d = sup;
        next_st.bsup_d = live_b;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            st <= ST_RST;
        else
            st <= next_st;
    end

    assign o_safe_off = st.safe_off;
    assign o_regular_off = st.reg_off;
    assign o_clamp_inhibit_delay = st.clamp_dly;
    assign o_drive_permit = !st.lock_a && !st.lock_b && st.rst_rdy_n && !pif.sec_rst;
    assign o_fault_a_notify_n = !st.lock_a;
    assign o_fault_b_notify_n = !st.lock_b;
    assign o_reset_ready_n = st.rst_rdy_n;
    assign o_sec_reset = pif.sec_rst;
    assign o_flags = st.flags;
    assign o_overcurrent_compare_status = st.ovc_stat;
    assign o_enable_valid_status = st.en_stat;
    assign o_pos_under_monitor_status = st.mon[gdp_pkg::SUP_PUV];
    assign o_pos_over_monitor_status = st.mon[gdp_pkg::SUP_POV];
    assign o_neg_under_monitor_status = st.mon[gdp_pkg::SUP_NUV];
    assign o_neg_over_monitor_status = st.mon[gdp_pkg::SUP_NOV];
    assign o_over_mode_select_mirror = pif.sel_m;
    assign o_over_mode_refresh_mirror = pif.ref_m;
    assign o_over_mode_active_status = pif.mode_active;
    assign o_neg_over_disable = st.neg_dis;

    a_ovc_off_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !i_out_on_cmd |=> (!o_overcurrent_compare_status && !o_safe_off))
        else $error("overcurrent evaluated while output off");
    a_ovc_event: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (on_ok && i_ocp_comp && o_fault_a_notify_n)
        |=> (o_safe_off && o_flags[gdp_pkg::FLG_OVC] && !o_fault_a_notify_n))
        else $error("overcurrent reaction missing");
    a_ovc_stat_blank: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !pif.blank_done |=> !o_overcurrent_compare_status)
        else $error("compare status not blanked");
    a_clamp_safe_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        o_safe_off |-> !o_clamp_inhibit_delay) else $error("clamp delay on safe turn-off");
    a_en_fall_event: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $fell(i_en_valid) |=> (o_regular_off && o_flags[gdp_pkg::FLG_EN] && !o_fault_a_notify_n))
        else $error("enable loss reaction missing");
    a_prim_uv_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_prim_uv |=> (!o_reset_ready_n && !o_drive_permit))
        else $error("reset/ready not low in primary undervoltage");
    a_prim_recover: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $fell(i_prim_uv) |=> (o_reset_ready_n && o_flags[gdp_pkg::FLG_PRST]))
        else $error("primary recovery not flagged");
    a_pos_uv_event: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(i_pos_uv) |=> (o_regular_off && o_flags[gdp_pkg::FLG_PUV] && !o_fault_b_notify_n))
        else $error("positive undervoltage reaction missing");
    a_pos_ov_notify: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (pif.mode_active && o_fault_b_notify_n && !b_ev && !prim_ev) |=> o_fault_b_notify_n)
        else $error("notify-only mode locked the output");
    a_neg_ov_disabled: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (st.neg_dis && !o_flags[gdp_pkg::FLG_NOV]) |=> !o_flags[gdp_pkg::FLG_NOV])
        else $error("disabled negative overvoltage flagged");

    for (genvar g = 0; g < gdp_pkg::NFLAG; g++)
    begin : g_sticky
        a_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
            (o_flags[g] && !i_flag_clr[g]) |=> o_flags[g]) else $error("error flag dropped");
    end
endmodule
`default_nettype wire

// ===== testbench/gdp_host_model.sv
// Host model driving the over-voltage mode select and refresh bits
`timescale 1ns/1ps
`default_nettype none
module gdp_host_model (
    input wire logic i_sys_clk, // System clock
    input wire logic i_sel,     // Wanted mode select
    input wire logic i_run,     // Keep refreshing the watchdog
    output logic o_sel,         // Mode select to the device
    output logic o_ref          // Mode refresh to the device
);
    logic [2:0] cnt = 3'h0;
    initial o_sel = 1'b0;
    initial o_ref = 1'b0;
    // A refresh rise every 8 cycles stays inside the 20 cycle watchdog
    always @(posedge i_sys_clk)
    begin
        cnt <= #2 cnt + 3'h1;
        o_sel <= #2 i_sel;
        o_ref <= #2 i_run & cnt[2];
    end
endmodule
`default_nettype wire

// ===== testbench/tb_gdp_protect.sv
// Self-checking bench of the gate driver protection block
`timescale 1ns/1ps
`default_nettype none
module tb_gdp_protect;
    logic clk = 1'b0, rst_b = 1'b0, on = 1'b0, oc = 1'b0, en = 1'b0, puv = 1'b0, below = 1'b0;
    logic sel = 1'b0, run = 1'b0, cwr = 1'b0, cdis = 1'b1, fast = 1'b0, rein = 1'b0;
    logic [3:0] sup = 4'h0;
    logic [7:0] blank = 8'h00, clr = 8'h00, flags;
    logic safe, reg_off, clamp, permit, fa_n, fb_n, rr_n, srst, ocs, ens, m0, m1, m2, m3;
    logic hsel, href, selm, refm, act, ndis;
    logic [2:0] exp_q[$];
    int bad_count = 0, samples_checked = 0, n;
    gdp_protect #(.P_WDOG_CYC(20)) u_gdp_protect (.i_sys_clk(clk), .i_rst_b(rst_b),
        .i_out_on_cmd(on), .i_ocp_comp(oc), .i_overcurrent_blanking_time(blank), .i_en_valid(en),
        .i_prim_uv(puv), .i_pos_uv(sup[0]), .i_pos_ov(sup[1]), .i_neg_uv(sup[2]), .i_neg_ov(sup[3]),
        .i_pos_below_rst(below), .i_over_mode_select_primary(hsel), .i_over_mode_refresh_primary(href),
        .i_cfg_wr(cwr), .i_cfg_neg_over_disable(cdis), .i_flag_clr(clr), .i_fast_react(fast),
        .i_reinit(rein), .o_safe_off(safe), .o_regular_off(reg_off), .o_clamp_inhibit_delay(clamp),
        .o_drive_permit(permit), .o_fault_a_notify_n(fa_n), .o_fault_b_notify_n(fb_n),
        .o_reset_ready_n(rr_n), .o_sec_reset(srst), .o_flags(flags), .o_overcurrent_compare_status(ocs),
        .o_enable_valid_status(ens), .o_pos_under_monitor_status(m0), .o_pos_over_monitor_status(m1),
        .o_neg_under_monitor_status(m2), .o_neg_over_monitor_status(m3), .o_over_mode_select_mirror(selm),
        .o_over_mode_refresh_mirror(refm), .o_over_mode_active_status(act), .o_neg_over_disable(ndis));
    gdp_host_model u_gdp_host_model (.i_sys_clk(clk), .i_sel(sel), .i_run(run), .o_sel(hsel), .o_ref(href));
    always #10 clk = ~clk;
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Nine bits so that a fault pin packed above the eight flags is compared as well
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    // Note the expected turn-off kind {safe, regular, clamp}, then wait for the watcher to take it
    task automatic expect_off(input logic [2:0] e, input int lim);
        exp_q.push_back(e);
        n = 0;
        while (exp_q.size() != 0 && n < lim)
        begin
            cyc(1);
            n++;
        end
        if (exp_q.size() != 0)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: turn-off never came", $time);
            end_sim();
        end
    endtask
    task automatic clear_all();
        fast = 1'b1;
        rein = 1'b1;
        clr = 8'hff;
        cyc(1);
        fast = 1'b0;
        rein = 1'b0;
        clr = 8'h00;
        cyc(2);
    endtask
    always @(posedge clk)
    begin
        #1;
        if ((safe | reg_off) === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(8'h01, 8'h00, "unexpected turn-off");
            else
                chk({safe, reg_off, clamp}, exp_q.pop_front(), "turn-off kind");
        end
        // The mirror takes the host bit that stood over the last edge; the host only moves it later
        if (rst_b === 1'b1 && srst === 1'b0)
            chk(refm, href, "refresh mirror");
    end
    initial
    begin
        void'($urandom(2));
        repeat (8) @(posedge clk);
        #2;
        rst_b = 1'b1;
        sup = 4'h8;
        cyc(4);
        chk(ndis, 1'b1, "disable default");
        chk(m3, 1'b1, "neg over live");
        chk(flags, 8'h00, "neg over ignored");
        sup = 4'h0;
        blank = 8'($urandom_range(4, 1));
        oc = 1'b1;
        cyc(3);
        chk(flags, 8'h00, "compare while off");
        on = 1'b1;
        exp_q.push_back(3'b100);
        repeat (5 * blank)
        begin
            cyc(1);
            chk(ocs, 1'b0, "status blanked");
        end
        chk(8'(exp_q.size()), 8'h01, "early safe off");
        // Withdraw the guard note so that only one safe turn-off is awaited
        if (exp_q.size() != 0)
            void'(exp_q.pop_back());
        expect_off(3'b100, 8);
        chk(ocs, 1'b1, "compare status");
        chk(fa_n, 1'b0, "fault a");
        on = 1'b0;
        oc = 1'b0;
        cyc(3);
        chk(flags, 8'h01, "flag kept");
        clear_all();
        chk(fa_n, 1'b1, "fast reactivation");
        en = 1'b1;
        cyc($urandom_range(6, 2));
        chk(ens, 1'b1, "enable valid");
        en = 1'b0;
        expect_off(3'b011, 6);
        chk({fa_n, flags[6:0]}, 8'h02, "enable flag");
        clear_all();
        cdis = 1'b0;
        cwr = 1'b1;
        cyc(1);
        cwr = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            sup = 4'(1 << k);
            expect_off(3'b011, 6);
            chk({4'h0, m3, m2, m1, m0}, {4'h0, sup}, "monitor status");
            chk(flags, 8'(8 << k), "supply flag");
            sup = 4'h0;
            cyc(2);
            chk({fb_n, permit}, 8'h00, "class b held");
            clear_all();
            chk({fb_n, permit}, 8'h03, "reinit releases");
        end
        puv = 1'b1;
        expect_off(3'b011, 6);
        chk(rr_n, 1'b0, "reset ready low");
        puv = 1'b0;
        cyc(2);
        chk({rr_n, flags[6:0]}, 8'h84, "primary recovery");
        clear_all();
        sel = 1'b1;
        run = 1'b1;
        cyc(12);
        chk({selm, act}, 8'h03, "mode mirrored");
        cyc(30);
        chk(act, 1'b1, "refresh holds mode");
        sup = 4'h2;
        cyc(3);
        chk({fb_n, flags}, 9'h110, "notify only");
        run = 1'b0;
        expect_off(3'b011, 40);
        chk({act, flags}, 9'h090, "mode timeout");
        sup = 4'h0;
        sel = 1'b0;
        clear_all();
        sel = 1'b1;
        run = 1'b1;
        cyc(12);
        sel = 1'b0;
        cyc(4);
        chk(act, 1'b0, "select off");
        below = 1'b1;
        cyc(2);
        chk({srst, permit, ndis}, 8'h05, "secondary reset");
        below = 1'b0;
        cyc(2);
        end_sim();
    end
endmodule
`default_nettype wire
